// file: rtl/banked_file_pkg.sv
// constants and types for the banked register file, program counter and return stack
package banked_file_pkg;

    // ==========================================================================
    // file addresses (bit 7 is the bank, bits 6:0 the file address)
    // ==========================================================================
    localparam logic [7:0] ADDR_INDIRECT_PORT = 8'h00;
    localparam logic [7:0] ADDR_TIMER_COUNT   = 8'h01;
    localparam logic [7:0] ADDR_PC_LOW_BYTE   = 8'h02;
    localparam logic [7:0] ADDR_CORE_STATUS   = 8'h03;
    localparam logic [7:0] ADDR_IND_POINTER   = 8'h04;
    localparam logic [7:0] ADDR_PORT_A_PINS   = 8'h05;
    localparam logic [7:0] ADDR_PORT_B_PINS   = 8'h06;
    localparam logic [7:0] ADDR_PORT_C_PINS   = 8'h07;
    localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h0A;
    localparam logic [7:0] ADDR_IRQ_CONTROL   = 8'h0B;
    localparam logic [7:0] ADDR_TIMER_CONFIG  = 8'h81;
    localparam logic [7:0] ADDR_PORT_A_DIR    = 8'h85;
    localparam logic [7:0] ADDR_PORT_B_DIR    = 8'h86;
    localparam logic [7:0] ADDR_PORT_C_DIR    = 8'h87;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h8E;

    // ==========================================================================
    // general purpose ram windows
    // ==========================================================================
    localparam logic [7:0] SPECIAL_SPAN    = 8'h20;
    localparam logic [7:0] RAM0_LO         = 8'h20;
    localparam logic [7:0] RAM0_HI_SMALL   = 8'h6F;
    localparam logic [7:0] RAM0_HI_LARGE   = 8'h7F;
    localparam logic [7:0] RAM1_LO         = 8'hA0;
    localparam logic [7:0] RAM1_HI         = 8'hBF;
    localparam logic [7:0] RAM1_BASE_INDEX = 8'h60;
    localparam int         RAM_WORDS       = 128;

    // ==========================================================================
    // field positions, reset values, apb layout
    // ==========================================================================
    localparam int          BANK_SELECT_BIT   = 5;
    localparam int          INDIRECT_BANK_BIT = 7;
    localparam logic [7:0]  STATUS_RESET      = 8'h18;
    localparam logic [7:0]  STATUS_RO_MASK    = 8'h18;
    localparam logic [7:0]  CONFIG_RESET      = 8'hFF;
    localparam logic [7:0]  DIR_RESET         = 8'hFF;
    localparam logic [12:0] IRQ_VECTOR        = 13'h0004;
    localparam logic [12:0] PC_RESET          = 13'h0000;
    localparam int          PC_W              = 13;
    localparam int          IMM_W             = 11;
    localparam int          STACK_DEPTH       = 8;
    localparam int          FILE_ADDR_W       = 7;
    localparam int          APB_INDEX_LSB     = 2;
    localparam int          APB_INDEX_MSB     = 8;
    localparam int          APB_TOP_LSB       = 9;

    // ==========================================================================
    // core commands and register kinds
    // ==========================================================================
    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_STEP   = 3'b001,
        OP_GOTO   = 3'b010,
        OP_CALL   = 3'b011,
        OP_RETURN = 3'b100,
        OP_RETLIT = 3'b101,
        OP_RETIRQ = 3'b110,
        OP_IRQ    = 3'b111
    } core_op_e;

    typedef struct packed {
        core_op_e           op;
        logic [IMM_W-1:0]   imm;
    } core_cmd_s;

    typedef enum logic [4:0] {
        K_NONE    = 5'h00, K_IND_PORT = 5'h01, K_TIMER   = 5'h02, K_PC_LOW = 5'h03,
        K_STATUS  = 5'h04, K_POINTER  = 5'h05, K_PA      = 5'h06, K_PB     = 5'h07,
        K_PC      = 5'h08, K_PC_LATCH = 5'h09, K_IRQ_CTL = 5'h0A, K_CONFIG = 5'h0B,
        K_TA      = 5'h0C, K_TB       = 5'h0D, K_TC      = 5'h0E, K_PWR_CTL = 5'h0F,
        K_RAM     = 5'h10
    } reg_kind_e;

endpackage

// file: rtl/banked_file_pc_stack.sv
// banked data memory, program counter loading and circular return stack behind apb
`timescale 1ns/1ps

module banked_file_pc_stack #(
    parameter bit LARGE_RAM = 1'b1
) (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    // execution core
    input  wire banked_file_pkg::core_cmd_s core_cmd,
    output logic      [12:0]                pc_out
);

    // ==========================================================================
    // state
    // ==========================================================================
    typedef struct packed {
        logic [12:0]       pc;
        logic [7:0]        pc_latch;
        logic [7:0]        status;
        logic [7:0]        ind_ptr;
        logic [7:0]        irq_ctl;
        logic [7:0]        timer;
        logic [7:0]        config_r;
        logic [7:0]        pa;
        logic [7:0]        pb;
        logic [7:0]        pcp;
        logic [7:0]        ta;
        logic [7:0]        tb;
        logic [7:0]        tc;
        logic [7:0]        pwr_ctl;
        logic [2:0]        sp;
        logic [7:0][12:0]  stack;
        logic [127:0][7:0] ram;
        logic [7:0]        rdata;
        logic              ready;
    } state_s;

    state_s                     s_r;
    state_s                     s_nxt;
    logic   [7:0]               direct_addr;
    logic   [7:0]               eff_addr;
    logic                       apb_ok;
    logic                       access;
    logic                       wr_commit;
    logic                       wr_pc_low;
    logic                       wr_latch;
    banked_file_pkg::reg_kind_e eff_kind;

    // ==========================================================================
    // address decode
    // ==========================================================================
    // classify a full 8-bit file address
    function automatic banked_file_pkg::reg_kind_e decode(input logic [7:0] a);
        logic [7:0] low;
        low = {1'b0, a[6:0]};
        decode = banked_file_pkg::K_NONE;
        if (low == banked_file_pkg::ADDR_INDIRECT_PORT) begin
            decode = banked_file_pkg::K_IND_PORT;
        end else if (low == banked_file_pkg::ADDR_PC_LOW_BYTE) begin
            decode = banked_file_pkg::K_PC_LOW;
        end else if (low == banked_file_pkg::ADDR_CORE_STATUS) begin
            decode = banked_file_pkg::K_STATUS;
        end else if (low == banked_file_pkg::ADDR_IND_POINTER) begin
            decode = banked_file_pkg::K_POINTER;
        end else if (low == banked_file_pkg::ADDR_PC_HIGH_LATCH) begin
            decode = banked_file_pkg::K_PC_LATCH;
        end else if (low == banked_file_pkg::ADDR_IRQ_CONTROL) begin
            decode = banked_file_pkg::K_IRQ_CTL;
        end else if (a == banked_file_pkg::ADDR_TIMER_COUNT) begin
            decode = banked_file_pkg::K_TIMER;
        end else if (a == banked_file_pkg::ADDR_PORT_A_PINS) begin
            decode = banked_file_pkg::K_PA;
        end else if (a == banked_file_pkg::ADDR_PORT_B_PINS) begin
            decode = banked_file_pkg::K_PB;
        end else if (a == banked_file_pkg::ADDR_PORT_C_PINS && LARGE_RAM) begin
            decode = banked_file_pkg::K_PC;
        end else if (a == banked_file_pkg::ADDR_TIMER_CONFIG) begin
            decode = banked_file_pkg::K_CONFIG;
        end else if (a == banked_file_pkg::ADDR_PORT_A_DIR) begin
            decode = banked_file_pkg::K_TA;
        end else if (a == banked_file_pkg::ADDR_PORT_B_DIR) begin
            decode = banked_file_pkg::K_TB;
        end else if (a == banked_file_pkg::ADDR_PORT_C_DIR && LARGE_RAM) begin
            decode = banked_file_pkg::K_TC;
        end else if (a == banked_file_pkg::ADDR_POWER_CONTROL) begin
            decode = banked_file_pkg::K_PWR_CTL;
        end else if (a >= banked_file_pkg::RAM0_LO && a <= (LARGE_RAM ?
                     banked_file_pkg::RAM0_HI_LARGE : banked_file_pkg::RAM0_HI_SMALL)) begin
            decode = banked_file_pkg::K_RAM;
        end else if (LARGE_RAM && a >= banked_file_pkg::RAM1_LO
                     && a <= banked_file_pkg::RAM1_HI) begin
            decode = banked_file_pkg::K_RAM;
        end
    endfunction

    // ram word index of an address that decodes as ram
    function automatic logic [6:0] ram_index(input logic [7:0] a);
        logic [7:0] idx;
        idx = a[7] ? (a - banked_file_pkg::RAM1_LO + banked_file_pkg::RAM1_BASE_INDEX)
                   : (a - banked_file_pkg::RAM0_LO);
        ram_index = idx[6:0];
    endfunction

    // direct address takes the bank from status, the port redirects through the pointer
    always_comb begin
        direct_addr = {s_r.status[banked_file_pkg::BANK_SELECT_BIT],
                       paddr[banked_file_pkg::APB_INDEX_MSB:banked_file_pkg::APB_INDEX_LSB]};
        // indirect bank bit is unused here: the pointer alone is the address
        eff_addr = (decode(direct_addr) == banked_file_pkg::K_IND_PORT) ? s_r.ind_ptr
                                                                    : direct_addr;
        eff_kind  = decode(eff_addr);
        apb_ok    = (paddr[31:banked_file_pkg::APB_TOP_LSB] == '0) && (paddr[1:0] == 2'b00);
        access    = psel && penable;
        wr_commit = access && s_r.ready && pwrite && apb_ok;
        wr_pc_low = wr_commit && (eff_kind == banked_file_pkg::K_PC_LOW);
        wr_latch  = wr_commit && (eff_kind == banked_file_pkg::K_PC_LATCH);
    end

    // ==========================================================================
    // next state
    // ==========================================================================
    always_comb begin
        s_nxt       = s_r;
        s_nxt.ready = 1'b0;

        // program counter and stack from the core; no overflow flag exists
        unique case (core_cmd.op)
            banked_file_pkg::OP_NONE: begin
            end
            banked_file_pkg::OP_STEP: begin
                s_nxt.pc = s_r.pc + 13'h0001;
            end
            banked_file_pkg::OP_GOTO: begin
                s_nxt.pc = {s_r.pc_latch[4:3], core_cmd.imm};
            end
            banked_file_pkg::OP_CALL: begin
                s_nxt.stack[s_r.sp] = s_r.pc + 13'h0001;
                s_nxt.sp            = s_r.sp + 3'd1;
                s_nxt.pc            = {s_r.pc_latch[4:3], core_cmd.imm};
            end
            banked_file_pkg::OP_IRQ: begin
                s_nxt.stack[s_r.sp] = s_r.pc;
                s_nxt.sp            = s_r.sp + 3'd1;
                s_nxt.pc            = banked_file_pkg::IRQ_VECTOR;
            end
            banked_file_pkg::OP_RETURN, banked_file_pkg::OP_RETLIT,
            banked_file_pkg::OP_RETIRQ: begin
                s_nxt.sp = s_r.sp - 3'd1;
                s_nxt.pc = s_r.stack[s_r.sp - 3'd1];
            end
        endcase

        // apb access phase: first cycle loads read data, second commits
        if (access && !s_r.ready) begin
            s_nxt.ready = 1'b1;
            s_nxt.rdata = 8'h00;
            if (apb_ok && !pwrite) begin
                unique case (eff_kind)
                    banked_file_pkg::K_NONE:   s_nxt.rdata = 8'h00;
                    banked_file_pkg::K_IND_PORT: s_nxt.rdata = 8'h00;
                    banked_file_pkg::K_TIMER:  s_nxt.rdata = s_r.timer;
                    banked_file_pkg::K_PC_LOW: s_nxt.rdata = s_r.pc[7:0];
                    banked_file_pkg::K_STATUS: s_nxt.rdata = s_r.status;
                    banked_file_pkg::K_POINTER: s_nxt.rdata = s_r.ind_ptr;
                    banked_file_pkg::K_PA:     s_nxt.rdata = s_r.pa;
                    banked_file_pkg::K_PB:     s_nxt.rdata = s_r.pb;
                    banked_file_pkg::K_PC:     s_nxt.rdata = s_r.pcp;
                    banked_file_pkg::K_PC_LATCH: s_nxt.rdata = s_r.pc_latch;
                    banked_file_pkg::K_IRQ_CTL: s_nxt.rdata = s_r.irq_ctl;
                    banked_file_pkg::K_CONFIG: s_nxt.rdata = s_r.config_r;
                    banked_file_pkg::K_TA:     s_nxt.rdata = s_r.ta;
                    banked_file_pkg::K_TB:     s_nxt.rdata = s_r.tb;
                    banked_file_pkg::K_TC:     s_nxt.rdata = s_r.tc;
                    banked_file_pkg::K_PWR_CTL: s_nxt.rdata = s_r.pwr_ctl;
                    banked_file_pkg::K_RAM:    s_nxt.rdata = s_r.ram[ram_index(eff_addr)];
                    default:                   s_nxt.rdata = 8'h00;
                endcase
            end
        end

        // write commits at the edge that completes the transfer; it wins over the core
        if (wr_commit) begin
            unique case (eff_kind)
                banked_file_pkg::K_NONE:   begin end
                banked_file_pkg::K_IND_PORT: begin end
                banked_file_pkg::K_TIMER:  s_nxt.timer    = pwdata[7:0];
                banked_file_pkg::K_PC_LOW: s_nxt.pc = {s_r.pc_latch[4:0], pwdata[7:0]};
                banked_file_pkg::K_STATUS: s_nxt.status =
                    (s_r.status & banked_file_pkg::STATUS_RO_MASK)
                    | (pwdata[7:0] & ~banked_file_pkg::STATUS_RO_MASK);
                banked_file_pkg::K_POINTER: s_nxt.ind_ptr = pwdata[7:0];
                banked_file_pkg::K_PA:     s_nxt.pa       = pwdata[7:0];
                banked_file_pkg::K_PB:     s_nxt.pb       = pwdata[7:0];
                banked_file_pkg::K_PC:     s_nxt.pcp      = pwdata[7:0];
                banked_file_pkg::K_PC_LATCH: s_nxt.pc_latch = pwdata[7:0];
                banked_file_pkg::K_IRQ_CTL: s_nxt.irq_ctl = pwdata[7:0];
                banked_file_pkg::K_CONFIG: s_nxt.config_r = pwdata[7:0];
                banked_file_pkg::K_TA:     s_nxt.ta       = pwdata[7:0];
                banked_file_pkg::K_TB:     s_nxt.tb       = pwdata[7:0];
                banked_file_pkg::K_TC:     s_nxt.tc       = pwdata[7:0];
                banked_file_pkg::K_PWR_CTL: s_nxt.pwr_ctl = pwdata[7:0];
                banked_file_pkg::K_RAM:    s_nxt.ram[ram_index(eff_addr)] = pwdata[7:0];
                default:                   begin end
            endcase
        end
    end

    // ==========================================================================
    // registers
    // ==========================================================================
    // stack pointer has no read or write path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.pc       <= banked_file_pkg::PC_RESET;
            s_r.status   <= banked_file_pkg::STATUS_RESET;
            s_r.config_r <= banked_file_pkg::CONFIG_RESET;
            s_r.ta       <= banked_file_pkg::DIR_RESET;
            s_r.tb       <= banked_file_pkg::DIR_RESET;
            s_r.tc       <= banked_file_pkg::DIR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign prdata = {24'h000000, s_r.rdata};
    assign pready = s_r.ready;
    assign pc_out = s_r.pc;

    // ==========================================================================
    // assertions
    // ==========================================================================
    a_pc_low_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_pc_low |=> s_r.pc == {$past(s_r.pc_latch[4:0]), $past(pwdata[7:0])})
        else $error("pc low byte write did not load pc from the latch");

    a_goto_target: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_cmd.op == banked_file_pkg::OP_GOTO && !wr_pc_low
        |=> s_r.pc == {$past(s_r.pc_latch[4:3]), $past(core_cmd.imm)})
        else $error("goto target wrong");

    a_call_push: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_cmd.op == banked_file_pkg::OP_CALL && !wr_pc_low
        |=> s_r.stack[$past(s_r.sp)] == $past(s_r.pc) + 13'h0001
            && s_r.pc[12:11] == $past(s_r.pc_latch[4:3]))
        else $error("call did not push the return address");

    a_ret_pops: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_cmd.op == banked_file_pkg::OP_CALL && !wr_pc_low
        ##1 core_cmd.op == banked_file_pkg::OP_RETURN && !wr_pc_low
        |=> s_r.pc == $past(s_r.pc, 2) + 13'h0001)
        else $error("return did not restore the call address");

    a_latch_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_cmd.op inside {banked_file_pkg::OP_CALL, banked_file_pkg::OP_IRQ,
                            banked_file_pkg::OP_RETURN, banked_file_pkg::OP_RETIRQ}
        && !wr_latch |=> $stable(s_r.pc_latch))
        else $error("stack action changed the pc high latch");

    a_sp_wraps: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_cmd.op == banked_file_pkg::OP_IRQ && s_r.sp == 3'd7 |=> s_r.sp == 3'd0)
        else $error("stack pointer did not wrap");

    a_irq_vector: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_cmd.op == banked_file_pkg::OP_IRQ && !wr_pc_low
        |=> s_r.pc == banked_file_pkg::IRQ_VECTOR)
        else $error("interrupt did not vector");

    a_ind_self_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && !s_r.ready && !pwrite && eff_kind == banked_file_pkg::K_IND_PORT
        |=> pready && prdata == 32'h00000000)
        else $error("indirect port read through pointer was not zero");

    a_unmapped_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && !s_r.ready && eff_kind == banked_file_pkg::K_NONE
        |=> pready && prdata == 32'h00000000 ##1 !pready)
        else $error("unmapped read not zero or ready not a pulse");

endmodule // banked_file_pc_stack

// file: testbench/core_model.sv
// execution core stand-in that issues commands into the block
`timescale 1ns/1ps
module core_model (
    // clock
    input  wire logic                  pclk,
    // commands
    output banked_file_pkg::core_cmd_s core_cmd
);
    initial core_cmd = '{banked_file_pkg::OP_NONE, 11'h000};
    // one command, then an idle spell of random length, so the core is prompt or slow
    task automatic send(input banked_file_pkg::core_op_e op, input logic [10:0] imm);
        core_cmd <= '{op, imm};
        @(posedge pclk);
        core_cmd <= '{banked_file_pkg::OP_NONE, 11'h000};
        repeat (1 + $urandom_range(0, 2)) @(posedge pclk);
    endtask
    // call straight followed by return on the next edge
    task automatic pair(input logic [10:0] imm);
        core_cmd <= '{banked_file_pkg::OP_CALL, imm};
        @(posedge pclk);
        core_cmd <= '{banked_file_pkg::OP_RETURN, 11'h000};
        @(posedge pclk);
        core_cmd <= '{banked_file_pkg::OP_NONE, 11'h000};
        repeat (2) @(posedge pclk);
    endtask
endmodule // core_model

// file: testbench/testbench.sv
// self-checking bench: apb file traffic and core commands against a behavioural model
`timescale 1ns/1ps
module testbench;
    // ==========================================================================
    // signals and model state
    // ==========================================================================
    logic                       pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic                       pwrite = 1'b0, pready;
    logic [31:0]                paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [12:0]                pc_out;
    banked_file_pkg::core_cmd_s core_cmd;
    int                         fail_count = 0, total_checks = 0, pc = 0, sp = 0, stk [8];
    bit   [7:0]                 m [256];
    // free-running clock
    always #10 pclk = ~pclk;
    banked_file_pc_stack #(.LARGE_RAM(1'b1)) banked_file_pc_stack_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .core_cmd(core_cmd),
        .pc_out(pc_out));
    core_model core_model_inst (.pclk(pclk), .core_cmd(core_cmd));
    // ==========================================================================
    // model helpers
    // ==========================================================================
    // full file address of an apb index, following the pointer for the port
    function automatic int eff(input int idx);
        int a;
        a = {m[8'h03][5], idx[6:0]};
        if (idx[6:0] == 7'h00) a = m[8'h04];
        if (a[6:0] inside {7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B}) a = a[6:0];
        return a;
    endfunction
    // implemented locations, special registers low and ram above
    function automatic bit impl(input int a);
        return a inside {[8'h01:8'h07], 8'h0A, 8'h0B, 8'h81, [8'h85:8'h87], 8'h8E,
            [8'h20:8'h7F], [8'hA0:8'hBF]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, checked and mirrored into the model
    task automatic apb(input bit wr, input int idx, input int d);
        int n, a;
        n = 0;
        a = eff(idx);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 32'(idx * 4), 32'(d & 8'hFF)};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) fail_count++;
        {psel, penable} <= 2'b00;
        if (!wr) chk(prdata, !impl(a) ? 0 : a == 2 ? pc & 8'hFF : m[a], "read");
        if (wr && impl(a)) begin
            m[a] = (a == 3) ? (d[7:0] & 8'hE7) | (m[3] & 8'h18) : d[7:0];
            if (a == 2) pc = {m[8'h0A][4:0], d[7:0]};
        end
    endtask
    // one core command, checked at pc_out
    task automatic run(input banked_file_pkg::core_op_e op, input int imm);
        if (op inside {banked_file_pkg::OP_CALL, banked_file_pkg::OP_IRQ}) begin
            stk[sp] = (op == banked_file_pkg::OP_IRQ) ? pc : (pc + 1) & 13'h1FFF;
            sp = (sp + 1) % 8;
        end
        if (op inside {[banked_file_pkg::OP_RETURN:banked_file_pkg::OP_RETIRQ]}) begin
            sp = (sp + 7) % 8;
            pc = stk[sp];
        end
        else if (op == banked_file_pkg::OP_IRQ) pc = banked_file_pkg::IRQ_VECTOR;
        else if (op == banked_file_pkg::OP_STEP) pc = (pc + 1) & 13'h1FFF;
        else if (op != banked_file_pkg::OP_NONE) pc = {m[8'h0A][4:3], imm[10:0]};
        core_model_inst.send(op, imm[10:0]);
        chk(32'(pc_out), 32'(pc), "pc");
    endtask
    // back-to-back call and return lands one past the calling address
    task automatic call_ret(input int imm);
        stk[sp] = (pc + 1) & 13'h1FFF;
        pc = stk[sp];
        core_model_inst.pair(imm[10:0]);
        chk(32'(pc_out), 32'(pc), "pc pair");
    endtask
    // read every index in both banks
    task automatic scan();
        for (int b = 0; b < 2; b++) begin
            apb(1, 8'h03, (m[3] & 8'hDF) | (b << 5));
            for (int i = 0; i < 128; i++) apb(0, i, 0);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================================
    // tests
    // ==========================================================================
    initial begin
        void'($urandom(32858));
        m[3] = banked_file_pkg::STATUS_RESET;
        m[8'h81] = banked_file_pkg::CONFIG_RESET;
        for (int i = 8'h85; i < 8'h88; i++) m[i] = banked_file_pkg::DIR_RESET;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(pc_out), 32'h0, "pc reset");
        scan();
        $display("test reset_map done");
        for (int i = 0; i < 300; i++) apb($urandom_range(0, 1), $urandom_range(0, 127), $urandom);
        scan();
        $display("test random_file done");
        apb(1, 8'h0A, $urandom);
        apb(1, 8'h02, $urandom);
        run(banked_file_pkg::OP_NONE, 0);
        for (int i = 0; i < 11; i++)
            run($urandom_range(0, 3) ? banked_file_pkg::OP_CALL : banked_file_pkg::OP_IRQ,
                $urandom);
        for (int i = 0; i < 10; i++)
            run(banked_file_pkg::core_op_e'(3'h4 + i % 3), 0);
        apb(0, 8'h0A, 0);
        for (int i = 0; i < 4; i++) call_ret($urandom);
        $display("test stack_wrap done");
        for (int i = 0; i < 150; i++) begin
            run(banked_file_pkg::core_op_e'($urandom_range(0, 7)), $urandom);
            if (i % 10 == 0) apb(1, $urandom_range(0, 1) ? 8'h02 : 8'h0A, $urandom);
        end
        $display("test random_ops done");
        wrap_up();
    end
    // watchdog against a hung handshake
    initial begin
        #1_000_000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule // testbench
